// ===== logic/svw_pkg.sv
/*
 * Shared constants for the service window supervisor: register offsets,
 * field positions, reset values, timing counts and the fault state type.
 * Assumes a 100 MHz pclk and one instruction-cycle tick input.
 */
package svw_pkg;

   // ==========================================================
   // register offsets (byte addresses, one word each)
   localparam logic [11:0] OFS_SVC = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h008;
   localparam logic [11:0] OFS_IDLE = 12'h00c;

   // ==========================================================
   // service_key_register layout
   localparam int SVC_WIN_HI = 7;
   localparam int SVC_WIN_LO = 6;
   localparam int SVC_KEY_HI = 5;
   localparam int SVC_KEY_LO = 1;
   localparam int SVC_CM_BIT = 0;
   localparam logic [4:0] KEY_VAL = 5'h0c;
   localparam logic [1:0] WIN_RST = 2'h3;
   localparam logic CM_RST = 1'b1;

   // ==========================================================
   // control and status bits
   localparam int CTRL_CLOCK_DELAY_SELECT_BIT = 0;
   localparam int CTRL_RC_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_FAULT_BIT = 1;
   localparam int STAT_FIRST_BIT = 2;
   localparam int STAT_CMERR_BIT = 3;

   // ==========================================================
   // timing, in instruction cycles unless named otherwise
   localparam logic [16:0] LOWER_LIMIT = 17'h00100;
   localparam logic [16:0] UPPER_BASE = 17'h02000;
   localparam logic [4:0] HOLD_CYC = 5'h10;
   localparam int IDLE_TICK_BIT = 12;
   localparam int CLK_PERIOD_NS = 10;
   // 10 Hz instruction clock period: slowest clock still accepted, any slower one rejected
   localparam int CM_REJECT_NS = 100000000;
   localparam int CM_LIMIT_CYC = CM_REJECT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      FS_RUN,
      FS_WAIT_LOW,
      FS_HOLD,
      FS_WAIT_HIGH
   } svw_fault_state_t;

endpackage : svw_pkg

// ===== logic/svw_clk_mon.sv
/*
 * Clock monitor: counts pclk cycles between instruction-cycle ticks and
 * flags an error once the gap reaches LIMIT.
 * Assumes inst_tick is a one-cycle pulse in the pclk domain.
 */
`timescale 1ns/1ns
module svw_clk_mon #(
   parameter int LIMIT = svw_pkg::CM_LIMIT_CYC,
   parameter int CNT_W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic mon_en,
   input wire logic inst_tick,
   output logic cm_err_q
);

   logic [CNT_W-1:0] gap_q;
   logic [CNT_W-1:0] gap_d;
   logic cm_err_d;

   // ==========================================================
   // gap counter
   always_comb
   begin
      gap_d = gap_q;
      cm_err_d = cm_err_q;
      if (!mon_en)
      begin
         gap_d = '0;
         cm_err_d = 1'b0;
      end
      else if (inst_tick)
      begin
         // a tick means the clock is back: error ends with it
         gap_d = '0;
         cm_err_d = 1'b0;
      end
      else if (gap_q == CNT_W'(LIMIT - 1))
         cm_err_d = 1'b1;
      else
         gap_d = gap_q + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_q <= '0;
         cm_err_q <= 1'b0;
      end
      else if (clk_en)
      begin
         gap_q <= gap_d;
         cm_err_q <= cm_err_d;
      end
   end

endmodule : svw_clk_mon

// ===== logic/svw_top.sv
/*
 * Service window supervisor with clock monitor, idle counter and an
 * APB register slave. Fault pin is open-drain, active low.
 * Assumes inst_tick, halt_mode and idle_mode come from pclk-domain logic;
 * the fault pin level comes back from outside and is synchronised.
 */
`timescale 1ns/1ns
module svw_top #(
   parameter int ADDR_W = 12,
   parameter int IDLE_W = 16,
   parameter int CM_LIMIT = svw_pkg::CM_LIMIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic inst_tick,
   input wire logic halt_mode,
   input wire logic idle_mode,
   input wire logic sup_fault_n_i,
   output logic sup_fault_n_o,
   output logic sup_fault_oe
);

   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic setup, wr_done, hit;
   logic [ADDR_W-1:0] ofs_svc, ofs_ctrl, ofs_stat, ofs_idle;
   logic [16:0] cnt_q, cnt_d, limit;
   logic [1:0] win_q, win_d, ctrl_q, ctrl_d;
   logic cm_en_q, cm_en_d, first_q, first_d, pend_q, pend_d;
   logic halt_q, idle_q, lowpow, run, key_ok, fields_ok;
   logic svc_wr, svc_bad, timeout, wd_err, halt_exit, idle_exit, reload;
   logic tick_toggle;
   logic [IDLE_W-1:0] idle_cnt_q, idle_cnt_d;
   logic pin_s1_q, pin_s2_q;
   svw_pkg::svw_fault_state_t fs_q, fs_d;
   logic [4:0] hold_q, hold_d;
   logic fault_n_q, fault_n_d, fault_oe_q, cm_err;

   assign ofs_svc = ADDR_W'(svw_pkg::OFS_SVC);
   assign ofs_ctrl = ADDR_W'(svw_pkg::OFS_CTRL);
   assign ofs_stat = ADDR_W'(svw_pkg::OFS_STAT);
   assign ofs_idle = ADDR_W'(svw_pkg::OFS_IDLE);
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sup_fault_n_o = fault_n_q;
   assign sup_fault_oe = fault_oe_q;

   // ==========================================================
   // APB slave: answer in the first cycle of the access phase
   always_comb
   begin
      setup = psel && !penable;
      wr_done = psel && penable && pwrite && pready_q;
      hit = (paddr == ofs_svc) || (paddr == ofs_ctrl) ||
         (paddr == ofs_stat) || (paddr == ofs_idle);
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = 32'h00000000;
      if (setup)
      begin
         pready_d = 1'b1;
         pslverr_d = !hit;
         if (!pwrite)
         begin
            if (paddr == ofs_svc)
            begin
               // key bits stay zero on purpose
               prdata_d[svw_pkg::SVC_WIN_HI:svw_pkg::SVC_WIN_LO] = win_q;
               prdata_d[svw_pkg::SVC_CM_BIT] = cm_en_q;
            end
            else if (paddr == ofs_ctrl)
               prdata_d[1:0] = ctrl_q;
            else if (paddr == ofs_stat)
            begin
               prdata_d[svw_pkg::STAT_PEND_BIT] = pend_q;
               prdata_d[svw_pkg::STAT_FAULT_BIT] = !run;
               prdata_d[svw_pkg::STAT_FIRST_BIT] = first_q;
               prdata_d[svw_pkg::STAT_CMERR_BIT] = cm_err;
            end
            else if (paddr == ofs_idle)
               prdata_d[IDLE_W-1:0] = idle_cnt_q;
         end
      end
      else if (psel && penable && !pready_q)
      begin
         pready_d = 1'b1;
         pslverr_d = pslverr_q;
         prdata_d = prdata_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else if (clk_en)
      begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================================
   // service window
   always_comb
   begin
      run = (fs_q == svw_pkg::FS_RUN);
      lowpow = halt_mode || idle_mode;
      limit = svw_pkg::UPPER_BASE << win_q;
      key_ok = (pwdata[svw_pkg::SVC_KEY_HI:svw_pkg::SVC_KEY_LO] ==
         svw_pkg::KEY_VAL);
      fields_ok = key_ok &&
         (pwdata[svw_pkg::SVC_WIN_HI:svw_pkg::SVC_WIN_LO] == win_q) &&
         (pwdata[svw_pkg::SVC_CM_BIT] == cm_en_q);
      // writes while the pin is driven are dropped
      svc_wr = wr_done && (paddr == ofs_svc) && run;
      // first write: key only, and no lower limit
      svc_bad = first_q ?
         (!fields_ok || (cnt_q < svw_pkg::LOWER_LIMIT)) :
         !key_ok;
      timeout = inst_tick && run && !lowpow &&
         (cnt_q == limit - 17'h00001);
      wd_err = (svc_wr && svc_bad) || timeout;
      idle_exit = idle_q && !idle_mode;
      halt_exit = halt_q && !halt_mode;
      reload = !(ctrl_q[svw_pkg::CTRL_RC_BIT] &&
         !ctrl_q[svw_pkg::CTRL_CLOCK_DELAY_SELECT_BIT]);
      cnt_d = cnt_q;
      win_d = win_q;
      cm_en_d = cm_en_q;
      first_d = first_q;
      ctrl_d = ctrl_q;
      if (!run)
         cnt_d = 17'h00000;
      else if (svc_wr && !svc_bad)
      begin
         cnt_d = 17'h00000;
         if (!first_q)
         begin
            win_d = pwdata[svw_pkg::SVC_WIN_HI:svw_pkg::SVC_WIN_LO];
            cm_en_d = pwdata[svw_pkg::SVC_CM_BIT];
            first_d = 1'b1;
         end
      end
      else if (idle_exit)
         cnt_d = 17'h00000;
      else if (halt_exit && reload)
         cnt_d = 17'h00000;
      else if (inst_tick && !lowpow)
         cnt_d = cnt_q + 17'h00001;
      if (wr_done && (paddr == ofs_ctrl))
         ctrl_d = pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 17'h00000;
         win_q <= svw_pkg::WIN_RST;
         cm_en_q <= svw_pkg::CM_RST;
         first_q <= 1'b0;
         ctrl_q <= svw_pkg::CTRL_RST;
         halt_q <= 1'b0;
         idle_q <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt_q <= cnt_d;
         win_q <= win_d;
         cm_en_q <= cm_en_d;
         first_q <= first_d;
         ctrl_q <= ctrl_d;
         halt_q <= halt_mode;
         idle_q <= idle_mode;
      end
   end

   // ==========================================================
   // idle counter: only power-on clears it
   always_comb
   begin
      tick_toggle = inst_tick &&
         (idle_cnt_q[svw_pkg::IDLE_TICK_BIT-1:0] == '1);
      idle_cnt_d = inst_tick ? idle_cnt_q + 1'b1 : idle_cnt_q;
      // set beats a clear in the same cycle
      pend_d = tick_toggle || (pend_q && !(wr_done &&
         (paddr == ofs_stat) && pwdata[svw_pkg::STAT_PEND_BIT]));
   end

   always_ff @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
         idle_cnt_q <= '0;
      else if (clk_en)
         idle_cnt_q <= idle_cnt_d;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_q <= 1'b0;
      else if (clk_en)
         pend_q <= pend_d;
   end

   // ==========================================================
   // clock monitor, awake in halt and idle as well
   svw_clk_mon #(
      .LIMIT(CM_LIMIT),
      .CNT_W(32)
   ) u_clk_mon (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .mon_en(cm_en_q),
      .inst_tick(inst_tick),
      .cm_err_q(cm_err)
   );

   // ==========================================================
   // fault pin: pull low, hold 16 ticks after pin reads low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end
      else if (clk_en)
      begin
         pin_s1_q <= sup_fault_n_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_comb
   begin
      fs_d = fs_q;
      hold_d = hold_q;
      case (fs_q)
         svw_pkg::FS_RUN:
            if (wd_err || cm_err)
               fs_d = svw_pkg::FS_WAIT_LOW;
         svw_pkg::FS_WAIT_LOW:
            if (!pin_s2_q)
            begin
               fs_d = svw_pkg::FS_HOLD;
               hold_d = 5'h00;
            end
         svw_pkg::FS_HOLD:
            // a slow clock keeps the pin low until it recovers
            if (cm_err)
               hold_d = 5'h00;
            else if (inst_tick)
            begin
               if (hold_q == svw_pkg::HOLD_CYC - 5'h01)
                  fs_d = svw_pkg::FS_WAIT_HIGH;
               else
                  hold_d = hold_q + 5'h01;
            end
         svw_pkg::FS_WAIT_HIGH:
            if (cm_err)
               fs_d = svw_pkg::FS_WAIT_LOW;
            else if (pin_s2_q)
               fs_d = svw_pkg::FS_RUN;
         default:
            fs_d = svw_pkg::FS_RUN;
      endcase
      fault_n_d = !((fs_d == svw_pkg::FS_WAIT_LOW) ||
         (fs_d == svw_pkg::FS_HOLD));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fs_q <= svw_pkg::FS_RUN;
         hold_q <= 5'h00;
         fault_n_q <= 1'b1;
         fault_oe_q <= 1'b0;
      end
      else if (clk_en)
      begin
         fs_q <= fs_d;
         hold_q <= hold_d;
         fault_n_q <= fault_n_d;
         fault_oe_q <= !fault_n_d;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_halt_exit;
      clk_en && halt_q && !halt_mode && run && !idle_exit && !svc_wr;
   endsequence

   a_valid_restart: assert property (
      clk_en && svc_wr && !svc_bad |=> cnt_q == 17'h00000 && run)
      else $error("valid service did not restart window");
   a_bad_fault: assert property (
      clk_en && svc_wr && svc_bad |=> !run ##1 !sup_fault_n_o)
      else $error("bad service did not drive fault");
   a_reset_defaults: assert property (
      !first_q |-> win_q == 2'h3 && cm_en_q)
      else $error("defaults lost before first service");
   a_first_key_only: assert property (
      clk_en && svc_wr && !first_q && key_ok |=> run && first_q)
      else $error("first service with good key refused");
   a_later_match: assert property (
      clk_en && svc_wr && first_q && !fields_ok |=> !run)
      else $error("mismatching later service accepted");
   a_key_read_zero: assert property (
      psel && penable && pready && !pwrite && paddr == ofs_svc
      |-> prdata[5:1] == 5'h00)
      else $error("key field visible on read");
   a_early_error: assert property (
      clk_en && svc_wr && first_q && cnt_q < 17'h00100 |=> !run)
      else $error("early service not flagged");
   a_lowpow_freeze: assert property (
      clk_en && lowpow && halt_q == halt_mode && idle_q == idle_mode
      && run && !svc_wr |=> $stable(cnt_q))
      else $error("window moved in low power");
   a_halt_resume: assert property (
      s_halt_exit and !reload |=> cnt_q == $past(cnt_q) ||
      cnt_q == $past(cnt_q) + 17'h00001)
      else $error("window not resumed after halt");
   a_halt_reload: assert property (
      s_halt_exit and reload |=> cnt_q == 17'h00000)
      else $error("window not reloaded after halt");
   a_idle_service: assert property (
      clk_en && idle_exit && run && !svc_wr |=> cnt_q == 17'h00000)
      else $error("no automatic service on idle exit");
   a_pend_set: assert property (
      clk_en && tick_toggle |=> pend_q)
      else $error("pending flag missed bit toggle");
   a_upper_limit: assert property (
      clk_en && timeout |=> fs_q == svw_pkg::FS_WAIT_LOW ##1 !sup_fault_n_o)
      else $error("window expiry not reported");

endmodule : svw_top

// ===== tb/svw_rst_link.sv
/*
 * Model of the circuit outside the fault pin: an open-drain wire with a
 * pull-up, optionally routed back to the device reset as a short pulse.
 * Assumes fault_oe high means the design pulls the pin to fault_n_o.
 */
`timescale 1ns/1ns
module svw_rst_link (
   input wire logic pclk,
   input wire logic link_en,
   input wire logic fault_n_o,
   input wire logic fault_oe,
   output logic pin_n,
   output logic dev_rst_n
);
   logic [2:0] hold_q = 3'h0;
   logic [2:0] hold_d;

   // ==========================================================
   // pin level and reset stretch
   // a released pin is pulled up, it never keeps its last driven value
   assign pin_n = fault_oe ? fault_n_o : 1'b1;

   // stretched so the device sees a clean pulse, not a zero-width glitch
   always_comb
   begin
      hold_d = hold_q;
      if (link_en && !pin_n)
         hold_d = 3'h4;
      else if (hold_q != 3'h0)
         hold_d = hold_q - 3'h1;
   end

   always_ff @(posedge pclk)
      hold_q <= hold_d;

   assign dev_rst_n = (hold_q == 3'h0);
endmodule : svw_rst_link

// ===== tb/svw_top_tb.sv
/*
 * Self-checking bench for svw_top: apb master, tick source, low-power
 * mode drive and the reset link model on the fault pin.
 * Assumes svw_pkg, svw_top and svw_rst_link are compiled first.
 */
`timescale 1ns/1ns
module svw_top_tb;
   localparam logic [11:0] A_SVC = svw_pkg::OFS_SVC;
   localparam logic [11:0] A_CTL = svw_pkg::OFS_CTRL;
   localparam logic [11:0] A_STA = svw_pkg::OFS_STAT;
   localparam logic [11:0] A_IDL = svw_pkg::OFS_IDLE;
   logic pclk, rst_n, por_n, psel, penable, pwrite, tick, halt, idle;
   logic tick_en, link_en, pready, pslverr, err, fo, oe, oe_q, pin_n;
   logic dev_rst_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsr, v;
   logic [1:0] w;
   logic [7:0] m;
   logic [1:0] ctl [4] = '{2'h2, 2'h0, 2'h3, 2'h2};
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int nflt = 0;
   wire presetn;

   assign presetn = rst_n & dev_rst_n;

   svw_top #(.CM_LIMIT(64)) dut_u (
      .pclk(pclk), .presetn(presetn), .por_n(por_n), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .inst_tick(tick), .halt_mode(halt),
      .idle_mode(idle), .sup_fault_n_i(pin_n), .sup_fault_n_o(fo),
      .sup_fault_oe(oe)
   );

   svw_rst_link link_u (
      .pclk(pclk), .link_en(link_en), .fault_n_o(fo), .fault_oe(oe),
      .pin_n(pin_n), .dev_rst_n(dev_rst_n)
   );

   // ==========================================================
   // clock, ticks, fault counter, timeout
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      tick <= tick_en & ~tick;
      oe_q <= oe;
      if (oe && !oe_q)
         nflt <= nflt + 1;
      cyc <= cyc + 1;
      if (cyc == 95000)
      begin
         miscompares++;
         close_out();
      end
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   function automatic logic [31:0] svc(input logic [1:0] wn,
      input logic [4:0] k, input logic cm);
      return {24'h0, wn, k, cm};
   endfunction : svc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (int n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] msk,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd & msk, exp);
   endtask : rdchk

   task automatic ticks(input int n);
      repeat (2 * n) @(posedge pclk);
   endtask : ticks

   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      repeat (n) @(posedge pclk);
      rst_n <= 1'b1;
      @(posedge pclk);
   endtask : do_reset

   // waits out pin hold, release and any linked reset pulse
   task automatic settle();
      for (int i = 0; i < 400 && (oe || !pin_n); i++)
         @(posedge pclk);
      repeat (12) @(posedge pclk);
   endtask : settle

   task automatic flt(input int exp);
      int n0;
      n0 = nflt;
      repeat (8) @(posedge pclk);
      chk(32'(nflt - n0), 32'(exp));
      settle();
   endtask : flt

   // ==========================================================
   // main sequence
   initial
   begin
      {psel, penable, pwrite, tick, halt, idle, tick_en} = 7'h00;
      {link_en, rst_n, por_n} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lfsr = 32'h7092e476;
      repeat (5) @(posedge pclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      tick_en <= 1'b1;
      @(posedge pclk);
      rdchk(A_SVC, 32'hff, svc(2'h3, 5'h00, 1'b1));
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      lfsr = nxt(lfsr);
      apb(1'b1, A_CTL, {30'h0, lfsr[1:0]});
      rdchk(A_CTL, 32'h3, {30'h0, lfsr[1:0]});
      apb(1'b1, A_STA, 32'h1);
      rdchk(A_STA, 32'h1, 32'h0);
      apb(1'b0, A_IDL, 32'h0);
      ticks(4096 - int'(rd[11:0]) - 8);
      rdchk(A_STA, 32'h1, 32'h0);
      ticks(16);
      rdchk(A_STA, 32'h1, 32'h1);
      apb(1'b1, A_STA, 32'h1);
      rdchk(A_STA, 32'h1, 32'h0);
      // long reset with no ticks: monitor must stay quiet
      tick_en <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, A_IDL, 32'h0);
      v = rd;
      do_reset(80);
      rdchk(A_IDL, 32'hffff, v & 32'hffff);
      chk({31'h0, oe}, 32'h0);
      tick_en <= 1'b1;
      lfsr = nxt(lfsr);
      w = lfsr[1:0];
      apb(1'b1, A_SVC, svc(w, svw_pkg::KEY_VAL, 1'b0));
      flt(0);
      rdchk(A_SVC, 32'hff, svc(w, 5'h00, 1'b0));
      for (int i = 0; i < 4; i++)
      begin
         lfsr = nxt(lfsr);
         m = (i == 0) ? 8'h40 : (i == 1) ? 8'h80 : (i == 2) ? 8'h01 :
            8'h02 << lfsr[1:0];
         ticks(300);
         apb(1'b1, A_SVC, svc(w, svw_pkg::KEY_VAL, 1'b0) ^ {24'h0, m});
         flt(1);
      end
      rdchk(A_SVC, 32'hff, svc(w, 5'h00, 1'b0));
      ticks(100);
      apb(1'b1, A_SVC, svc(w, svw_pkg::KEY_VAL, 1'b0));
      flt(1);
      ticks(300);
      apb(1'b1, A_SVC, svc(w, svw_pkg::KEY_VAL, 1'b0));
      flt(0);
      do_reset(5);
      apb(1'b1, A_SVC, svc(2'h3, 5'h0d, 1'b1));
      flt(1);
      // stopped clock in halt with the monitor left on
      do_reset(5);
      v = 32'(nflt);
      halt <= 1'b1;
      tick_en <= 1'b0;
      repeat (100) @(posedge pclk);
      rdchk(A_STA, 32'ha, 32'ha);
      chk(32'(nflt) - v, 32'h1);
      tick_en <= 1'b1;
      halt <= 1'b0;
      settle();
      // fault pin routed back as device reset
      do_reset(5);
      link_en <= 1'b1;
      apb(1'b1, A_SVC, svc(2'h0, svw_pkg::KEY_VAL, 1'b0));
      ticks(300);
      apb(1'b1, A_SVC, svc(2'h1, svw_pkg::KEY_VAL, 1'b0));
      settle();
      link_en <= 1'b0;
      rdchk(A_SVC, 32'hff, svc(2'h3, 5'h00, 1'b1));
      rdchk(A_STA, 32'h4, 32'h0);
      // low-power exits: resume, reload twice, idle auto service
      for (int c = 0; c < 4; c++)
      begin
         do_reset(5);
         v = 32'(nflt);
         apb(1'b1, A_CTL, {30'h0, ctl[c]});
         apb(1'b1, A_SVC, svc(2'h0, svw_pkg::KEY_VAL, 1'b0));
         ticks(7950);
         halt <= (c != 3);
         idle <= (c == 3);
         tick_en <= 1'b0;
         repeat (80) @(posedge pclk);
         tick_en <= 1'b1;
         ticks(300);
         halt <= 1'b0;
         idle <= 1'b0;
         ticks(150);
         chk(32'(nflt) - v, 32'h0);
         ticks(150);
         chk(32'(nflt) - v, 32'(c == 0));
         settle();
      end
      close_out();
   end
endmodule : svw_top_tb
